// ==== core/pscr_defs.svh ====
// Offsets, field positions, reset values and register width for the PLL status and control block.
// What this block does
// R1: Two 16-bit registers: lock state at word 0, reset and detector control at word 1.
// R2: Writes to word 0 change nothing.
// R3: Status bit 0 shows lock; reads 1 after reset.
// R4: Writing 1 to control bit 0 pulses PLL reset exactly one cycle; reads 0 after.
// R5: Control bit 1 drives the phase detector enable directly; resets to 1.
// R6: Control register bits read back at word 1.
// R7: Reserved bits read undefined (zero here); software writes them zero.
// R8: A bit exists only if its signal is generated and register-mapped.
// R9: Exported advanced signals become top-level ports instead of register bits.
// R10: Basic PLL signals are always ports, never registers.
// R11: PLL enable is always a port; absent means permanently enabled.
// R12: Absent PLL reset input means reset only at configuration, no run-time path.
// R13: Absent phase detector enable means detector permanently enabled.
// R14: PLL reset request also resets the whole system module.
// R15: Detector enable gates tracking of reference changes.
// R16: External PLL output clocks drive pins only, never internal logic.
// R17: At configuration hold system reset asserted until the PLL reports lock. With HAS_LOCKED 0 the code releases it without lock.
// R18: Lock indication is synchronised into the bus clock before status use.
`ifndef PSCR_DEFS_SVH
`define PSCR_DEFS_SVH

`define PSCR_OFS_STATUS   1'h0
`define PSCR_OFS_CONTROL  1'h1
`define PSCR_DATA_W       16
`define PSCR_BIT_LOCK     0
`define PSCR_BIT_ARESET   0
`define PSCR_BIT_PFDENA   1
`define PSCR_RST_LOCK     1'h1
`define PSCR_RST_ARESET   1'h0
`define PSCR_RST_PFDENA   1'h1
`define PSCR_RST_PLLENA   1'h1
`define PSCR_RST_HOLDLK   1'h0
`define PSCR_ZERO16       16'h0000

`endif

// ==== core/pscr_pkg.sv ====
// Types shared by the PLL status and control block.
package pscr_pkg;
    // One register access from the software side.
    typedef struct packed {
        logic        cs;     // Chip select.
        logic        wr;     // Write strobe.
        logic        rd;     // Read strobe.
        logic        addr;   // Word offset.
        logic [15:0] wdata;  // Write data.
    } pscr_req_t;

    // Controls going to the PLL circuitry.
    typedef struct packed {
        logic areset;        // PLL reset request.
        logic pfdena;        // Phase detector enable.
    } pscr_pll_ctl_t;

    // Reset hold state machine states, one-hot.
    typedef enum logic [1:0] {
        PSCR_HOLD = 2'b01,
        PSCR_RUN  = 2'b10
    } pscr_rst_st_t;
endpackage

// ==== core/pscr_sync.sv ====
// Two flip-flop synchroniser for one asynchronous level.
module pscr_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk_i,   // Bus clock.
    input  wire logic rst_i,   // Asynchronous reset, active high.
    input  wire logic d_i,     // Asynchronous level.
    output logic      q_o      // Synchronised level.
);
    logic meta_q;

    // The first stage feeds only the second, so metastability never reaches logic.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= RST_VAL;
            q_o    <= RST_VAL;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule

// ==== core/pscr_top.sv ====
// Register wrapper giving software status and control of an on-chip PLL.
`include "pscr_defs.svh"

module pscr_top #(
    parameter bit HAS_ARESET = 1'b1,  // PLL reset input generated.
    parameter bit REG_ARESET = 1'b1,  // PLL reset mapped to register, else exported.
    parameter bit HAS_PFDENA = 1'b1,  // Detector enable generated.
    parameter bit REG_PFDENA = 1'b1,  // Detector enable mapped to register.
    parameter bit HAS_LOCKED = 1'b1,  // Lock output generated.
    parameter bit REG_LOCKED = 1'b1   // Lock mapped to register.
) (
    input  wire logic                  clk_i,         // Bus clock, 125 MHz.
    input  wire logic                  rst_i,         // Asynchronous reset, active high.
    input  wire pscr_pkg::pscr_req_t   req_i,         // Register access.
    output logic [15:0]                rdata_o,       // Read data.
    output logic                       rvalid_o,      // Read data valid pulse.
    input  wire logic                  pll_locked_i,  // Asynchronous lock from PLL.
    input  wire logic                  exp_areset_i,  // Exported reset request.
    input  wire logic                  exp_pfdena_i,  // Exported detector enable.
    input  wire logic                  exp_pllena_i,  // PLL enable, always a port.
    output pscr_pkg::pscr_pll_ctl_t    pll_ctl_o,     // Controls to the PLL.
    output logic                       pll_ena_o,     // PLL enable to the PLL.
    output logic                       exp_locked_o,  // Exported lock level.
    output logic                       sys_rst_o      // System-wide reset.
);
    // ------------------------------------------------------------------
    // Build-time checks
    // ------------------------------------------------------------------
    // Refused at elaboration, so a bad width never reaches a netlist.
    if (`PSCR_DATA_W != 16) begin : g_width_check
        $error("pscr_top: register width must be 16");
    end

    localparam bit MAP_ARESET = HAS_ARESET && REG_ARESET;
    localparam bit MAP_PFDENA = HAS_PFDENA && REG_PFDENA;
    localparam bit MAP_LOCKED = HAS_LOCKED && REG_LOCKED;

    // ------------------------------------------------------------------
    // Lock synchronisation
    // ------------------------------------------------------------------
    logic lock_s;
    logic lock_h;

    // R18: synchronise lock level
    pscr_sync #(
        .RST_VAL (`PSCR_RST_LOCK)
    ) u_lock_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (pll_locked_i),
        .q_o   (lock_s)
    );

    // R17 R18: lock copy for hold
    // This copy resets to unlocked, unlike the status copy, so the hold never
    // trusts the status bit's reset value and, with HAS_LOCKED set, only ends on a lock really seen.
    pscr_sync #(
        .RST_VAL (`PSCR_RST_HOLDLK)
    ) u_hold_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (pll_locked_i),
        .q_o   (lock_h)
    );

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    function automatic logic hit(input pscr_pkg::pscr_req_t r, input logic ofs);
        hit = r.cs && (r.addr == ofs);
    endfunction

    logic wr_ctl;
    logic rd_any;
    // R2: only the control word takes writes
    assign wr_ctl = req_i.wr && hit(req_i, `PSCR_OFS_CONTROL);
    assign rd_any = req_i.rd && req_i.cs;

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic pfdena_q;
    logic areset_q;
    logic areset_exp_q;

    // R5: detector enable stored bit
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pfdena_q <= `PSCR_RST_PFDENA;
        end else if (wr_ctl && MAP_PFDENA) begin
            pfdena_q <= req_i.wdata[`PSCR_BIT_PFDENA];
        end
    end

    // R4: single-cycle reset pulse
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            areset_q <= `PSCR_RST_ARESET;
        end else begin
            areset_q <= wr_ctl && MAP_ARESET && req_i.wdata[`PSCR_BIT_ARESET];
        end
    end

    // Exported reset request is a same-clock input, registered for a flop output.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            areset_exp_q <= `PSCR_RST_ARESET;
        end else begin
            areset_exp_q <= exp_areset_i;
        end
    end

    // ------------------------------------------------------------------
    // PLL-facing outputs
    // ------------------------------------------------------------------
    // R9 R10 R11 R12 R13 R15: select mapped, exported or default drive
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pll_ctl_o.areset <= `PSCR_RST_ARESET;
            pll_ctl_o.pfdena <= `PSCR_RST_PFDENA;
            pll_ena_o        <= `PSCR_RST_PLLENA;
            exp_locked_o     <= `PSCR_RST_LOCK;
        end else begin
            pll_ctl_o.areset <= !HAS_ARESET ? 1'b0 :
                                (MAP_ARESET ? areset_q : areset_exp_q);
            pll_ctl_o.pfdena <= !HAS_PFDENA ? 1'b1 :
                                (MAP_PFDENA ? pfdena_q : exp_pfdena_i);
            pll_ena_o        <= exp_pllena_i;
            exp_locked_o     <= (HAS_LOCKED && !REG_LOCKED) ? lock_s : 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // System reset hold
    // ------------------------------------------------------------------
    pscr_pkg::pscr_rst_st_t st_q;

    // R17: hold system reset until lock; R14: PLL reset restarts the hold
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q      <= pscr_pkg::PSCR_HOLD;
            sys_rst_o <= 1'b1;
        end else begin
            case (st_q)
                pscr_pkg::PSCR_HOLD: begin
                    if (lock_h || !HAS_LOCKED) begin
                        st_q      <= pscr_pkg::PSCR_RUN;
                        sys_rst_o <= 1'b0;
                    end
                end
                pscr_pkg::PSCR_RUN: begin
                    if (pll_ctl_o.areset) begin
                        st_q      <= pscr_pkg::PSCR_HOLD;
                        sys_rst_o <= 1'b1;
                    end
                end
                default: begin
                    st_q      <= pscr_pkg::PSCR_HOLD;
                    sys_rst_o <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // R1 R3 R6 R7 R8: absent and reserved bits read as zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o  <= `PSCR_ZERO16;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_any;
            rdata_o  <= `PSCR_ZERO16;
            if (rd_any && req_i.addr == `PSCR_OFS_STATUS) begin
                rdata_o[`PSCR_BIT_LOCK] <= MAP_LOCKED && lock_s;
            end else if (rd_any) begin
                rdata_o[`PSCR_BIT_PFDENA] <= MAP_PFDENA && pfdena_q;
                rdata_o[`PSCR_BIT_ARESET] <= MAP_ARESET && areset_q;
            end
        end
    end
    // R16: no clock port from the PLL exists, so no PLL clock drives logic here.

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_set_write;
        wr_ctl && MAP_ARESET && req_i.wdata[`PSCR_BIT_ARESET];
    endsequence

    property p_areset_pulse;
        @(posedge clk_i) disable iff (rst_i)
        s_set_write |=> areset_q ##1 !areset_q || $past(wr_ctl);
    endproperty
    a_areset_pulse: assert property (p_areset_pulse) else $error("reset pulse not one cycle"); // R4

    property p_status_no_write;
        @(posedge clk_i) disable iff (rst_i)
        (req_i.wr && hit(req_i, `PSCR_OFS_STATUS)) |=> $stable(pfdena_q) && !areset_q;
    endproperty
    a_status_no_write: assert property (p_status_no_write) else $error("status write had effect"); // R2

    property p_pfdena_follow;
        @(posedge clk_i) disable iff (rst_i)
        (wr_ctl && MAP_PFDENA) |=> ##1
            pll_ctl_o.pfdena == $past(req_i.wdata[`PSCR_BIT_PFDENA], 2);
    endproperty
    a_pfdena_follow: assert property (p_pfdena_follow) else $error("detector enable wrong"); // R5

    property p_ctl_readback;
        @(posedge clk_i) disable iff (rst_i)
        (rd_any && req_i.addr == `PSCR_OFS_CONTROL) |=>
            rvalid_o && rdata_o[`PSCR_BIT_PFDENA] == (MAP_PFDENA && $past(pfdena_q));
    endproperty
    a_ctl_readback: assert property (p_ctl_readback) else $error("control readback wrong"); // R6

    property p_lock_read;
        @(posedge clk_i) disable iff (rst_i)
        (rd_any && req_i.addr == `PSCR_OFS_STATUS) |=>
            rdata_o[`PSCR_BIT_LOCK] == (MAP_LOCKED && $past(lock_s)) && rdata_o[15:1] == 15'h0;
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("status read wrong"); // R3

    property p_hold_reset;
        @(posedge clk_i) disable iff (rst_i)
        (st_q == pscr_pkg::PSCR_HOLD) |-> sys_rst_o;
    endproperty
    a_hold_reset: assert property (p_hold_reset) else $error("system reset released early"); // R17

    property p_release_after_lock;
        @(posedge clk_i) disable iff (rst_i)
        $fell(sys_rst_o) |-> ($past(lock_h) || !HAS_LOCKED);
    endproperty
    a_release_after_lock: assert property (p_release_after_lock) else $error("released without lock"); // R17

    property p_areset_sysrst;
        @(posedge clk_i) disable iff (rst_i)
        pll_ctl_o.areset && st_q == pscr_pkg::PSCR_RUN |=> sys_rst_o;
    endproperty
    a_areset_sysrst: assert property (p_areset_sysrst) else $error("PLL reset missed system"); // R14

    property p_pllena;
        @(posedge clk_i) disable iff (rst_i)
        ##1 pll_ena_o == $past(exp_pllena_i);
    endproperty
    a_pllena: assert property (p_pllena) else $error("PLL enable not from port"); // R11
endmodule

// ==== tb/pscr_host.sv ====
// Bus master model that issues register reads and writes to the block.
module pscr_host (
    input  wire logic          clk_i,    // Bus clock.
    output pscr_pkg::pscr_req_t req_o,   // Register access.
    input  wire logic [15:0]   rdata_i,  // Read data.
    input  wire logic          rvalid_i  // Read data valid.
);
    timeunit 1ns;
    timeprecision 1ps;

    // The bus starts idle so nothing is taken during reset.
    initial begin
        req_o = '0;
    end

    // reserved bits zero, request held over one rising edge.
    // An idle bus shows inverted data, so a stale word never looks valid.
    task automatic access(input logic w, input logic a, input logic [15:0] d);
        @(negedge clk_i);
        req_o = '{cs: 1'b1, wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk_i);
        req_o = '{cs: 1'b0, wr: 1'b0, rd: 1'b0, addr: !a, wdata: ~d};
    endtask

    // Read one word and wait a bounded time for the valid pulse.
    // The pulse stands for one cycle only, so it is looked at on the falling
    // edge at which the request is released, while it is still settled.
    task automatic rd(input logic a, output logic [15:0] d, output logic ok);
        ok = 1'b0;
        d = 16'h0000;
        access(1'b0, a, 16'h0000);
        for (int i = 0; i < 3 && !ok; i++) begin
            if (rvalid_i === 1'b1) begin
                d = rdata_i;
                ok = 1'b1;
            end else begin
                @(negedge clk_i);
            end
        end
    endtask
endmodule

// ==== tb/pscr_top_bench.sv ====
// Self-checking bench for the PLL status and control register block.
module pscr_top_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                    clk_i, rst_i, locked, exp_ar, exp_pf, pllena;
    logic                    rvalid, ena_o, exp_lk, sys_rst, rd_ok;
    logic [15:0]             rdata, rd_val;
    pscr_pkg::pscr_req_t     req;
    pscr_pkg::pscr_pll_ctl_t ctl;
    int                      error_cnt, samples_checked, n;

    pscr_top dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata),
        .rvalid_o(rvalid), .pll_locked_i(locked), .exp_areset_i(exp_ar),
        .exp_pfdena_i(exp_pf), .exp_pllena_i(pllena), .pll_ctl_o(ctl),
        .pll_ena_o(ena_o), .exp_locked_o(exp_lk), .sys_rst_o(sys_rst));
    pscr_host host (.clk_i(clk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Free-running 125 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Compare one value, count it, and report a mismatch at once.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Print the counts and the verdict, then stop.
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // A read that never answers ends the run as a failure.
    task automatic rd_chk(input logic a, input logic [15:0] exp);
        host.rd(a, rd_val, rd_ok);
        if (rd_ok !== 1'b1) begin
            error_cnt++;
            $display("FAIL %0t read timed out", $time);
            tally_and_finish();
        end else begin
            chk(rd_val, exp);
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // reset values, then release once lock is seen.
    task automatic t_reset();
        rst_i = 1'b1;
        repeat (6) @(negedge clk_i);
        chk({14'h0000, ctl}, 16'h0001);
        chk({15'h0000, sys_rst}, 16'h0001);
        rst_i = 1'b0;
        n = 0;
        while (sys_rst !== 1'b0 && n < 8) begin
            @(negedge clk_i);
            n++;
        end
        chk({15'h0000, sys_rst}, 16'h0000);
        rd_chk(1'b0, 16'h0001);
        rd_chk(1'b1, 16'h0002);
    endtask

    // a write to the status word changes nothing.
    task automatic t_status_ro();
        host.access(1'b1, 1'b0, 16'h0000);
        rd_chk(1'b0, 16'h0001);
        rd_chk(1'b1, 16'h0002);
    endtask

    // one-cycle reset pulse, which also resets the system.
    task automatic t_areset();
        int hits;
        hits = 0;
        n = 0;
        host.access(1'b1, 1'b1, 16'h0003);
        repeat (8) begin
            @(negedge clk_i);
            hits += ctl.areset;
            n += sys_rst;
        end
        chk(16'(hits), 16'h0001);
        chk({15'h0000, n > 0}, 16'h0001);
        chk({15'h0000, ctl.pfdena}, 16'h0001);
        rd_chk(1'b1, 16'h0002);
    endtask

    // detector enable follows the register, not the export pin.
    task automatic t_pfdena();
        exp_pf = 1'b1;
        host.access(1'b1, 1'b1, 16'h0000);
        repeat (2) @(negedge clk_i);
        chk({15'h0000, ctl.pfdena}, 16'h0000);
        rd_chk(1'b1, 16'h0000);
        exp_pf = 1'b0;
        host.access(1'b1, 1'b1, 16'h0002);
        repeat (2) @(negedge clk_i);
        chk({15'h0000, ctl.pfdena}, 16'h0001);
        rd_chk(1'b1, 16'h0002);
    endtask

    // lock loss shows in status after synchronising.
    task automatic t_lock();
        locked = 1'b0;
        repeat (4) @(negedge clk_i);
        rd_chk(1'b0, 16'h0000);
        chk({15'h0000, exp_lk}, 16'h0000);
        locked = 1'b1;
        repeat (4) @(negedge clk_i);
        rd_chk(1'b0, 16'h0001);
    endtask

    // the PLL enable port passes straight through.
    task automatic t_pllena();
        pllena = 1'b0;
        repeat (3) @(negedge clk_i);
        chk({15'h0000, ena_o}, 16'h0000);
        pllena = 1'b1;
        repeat (3) @(negedge clk_i);
        chk({15'h0000, ena_o}, 16'h0001);
    endtask

    // Main sequence; exported reset stays low since it is unused here.
    initial begin
        error_cnt = 0;
        samples_checked = 0;
        rst_i = 1'b1;
        locked = 1'b1;
        exp_ar = 1'b0;
        exp_pf = 1'b0;
        pllena = 1'b1;
        t_reset();
        t_status_ro();
        t_areset();
        t_pfdena();
        t_lock();
        t_pllena();
        tally_and_finish();
    end
endmodule
